// File: core/vectored_interrupt_pkg.sv
// Constants, register map and state encoding for the vectored interrupt unit.
// Assumes an 8-bit register port and a core that stacks and fetches on request.
// Overview of operation
// - Break with mask clear stacks PC and status, sets mask, vectors 7ffe/7fff.
// - A rising reset pin starts a six cycle initialization before running.
// - After init set mask, clear decimal, load PC from 7ffc low, 7ffd high.
// - Selected external edge sets its flag; taken if enabled and unmasked, 7ff8.
// - DAC reload sets its flag; taken if enabled and unmasked, vector 7ff6.
// - Timer zero overflow sets its flag; enabled requests vector through 7ff4.
// - Timer one overflow sets its flag; enabled requests vector through 7ff2.
// - Port transition sets its flag; enabled requests vector through 7ff0.
// - Base timer overflow sets its flag; enabled, unmasked requests vector 7fee.
// - Hardware entry pushes PC then status and sets the mask before fetching.
// - Fixed priority reset, edge, DAC, timer0, timer1, port, base, break; 7ffa reserved.
// - Writing zero to a request bit clears it; flags otherwise hold.
// - Starting service of a source clears its request flag automatically.
// - Request bits: base 5, port 4, timer1 3, timer0 2, DAC 1, edge 0.
// - Enable register mirrors request layout; both reset to zero.
// - Edge select bit one picks rising edge, zero picks falling edge.
// - Port request raised while port A differs from value latched at last read.

package vectored_interrupt_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] REQUEST_FLAGS_OFFSET = 8'h3c;
  localparam logic [7:0] ENABLE_MASK_OFFSET   = 8'h3e;
  localparam logic [7:0] EDGE_CONTROL_OFFSET  = 8'h0f;
  localparam logic [7:0] EVENT_STATUS_OFFSET  = 8'h3d;
  localparam logic [7:0] EVENT_MASK_OFFSET    = 8'h3f;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int         SOURCE_COUNT      = 6;
  localparam int         EXT_EDGE_BIT      = 0;
  localparam int         DAC_RELOAD_BIT    = 1;
  localparam int         TIMER_ZERO_BIT    = 2;
  localparam int         TIMER_ONE_BIT     = 3;
  localparam int         PORT_CHANGE_BIT   = 4;
  localparam int         BASE_TIMER_BIT    = 5;
  localparam int         EDGE_POLARITY_BIT = 5;
  localparam int         STATUS_BREAK_BIT  = 4;
  localparam int         EVENT_COUNT       = 3;
  localparam int         EVENT_RESET_BIT   = 0;
  localparam int         EVENT_BREAK_BIT   = 1;
  localparam int         EVENT_HW_BIT      = 2;
  localparam logic [5:0] REQUEST_RESET     = 6'h00;
  localparam logic [5:0] ENABLE_RESET      = 6'h00;
  localparam logic [2:0] EVENT_RESET_VALUE = 3'h0;

  // ****************************************************************
  // Vectors, low byte addresses
  // ****************************************************************
  localparam logic [15:0] BREAK_VECTOR    = 16'h7ffe;
  localparam logic [15:0] RESET_VECTOR    = 16'h7ffc;
  localparam logic [15:0] RESERVED_VECTOR = 16'h7ffa;
  localparam logic [15:0] SOURCE_VECTOR [SOURCE_COUNT] = '{
    16'h7ff8, 16'h7ff6, 16'h7ff4, 16'h7ff2, 16'h7ff0, 16'h7fee};

  // ****************************************************************
  // Cycle counts
  // ****************************************************************
  localparam logic [2:0] INIT_CYCLES     = 3'd6;
  localparam logic [1:0] LOW_HOLD_CYCLES = 2'd2;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [8:0] {
    ST_HALT     = 9'h001,
    ST_INIT     = 9'h002,
    ST_IDLE     = 9'h004,
    ST_PUSH_HI  = 9'h008,
    ST_PUSH_LO  = 9'h010,
    ST_PUSH_P   = 9'h020,
    ST_FETCH_LO = 9'h040,
    ST_FETCH_HI = 9'h080,
    ST_LOAD     = 9'h100
  } seq_state_e;

endpackage : vectored_interrupt_pkg

// File: core/pin_filter.sv
// Three-stage input filter for pins from outside the clock domain.
// Assumes a single clock; the stable value moves once stages two and three agree.
`timescale 1ns/1ns
module pin_filter #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] stable
);

  // ****************************************************************
  // Per-bit synchroniser
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage_one;
      logic stage_two;
      logic stage_three;
      // First stage feeds only the second, to keep metastability contained
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          stage_one   <= RESET_VALUE[i];
          stage_two   <= RESET_VALUE[i];
          stage_three <= RESET_VALUE[i];
          stable[i]   <= RESET_VALUE[i];
        end else if (clk_en) begin
          stage_one   <= pin_in[i];
          stage_two   <= stage_one;
          stage_three <= stage_two;
          if (stage_two == stage_three) begin
            stable[i] <= stage_three;
          end
        end
      end
    end
  endgenerate

endmodule : pin_filter

// File: core/vectored_interrupt_unit.sv
// Vectored interrupt and reset entry sequencer for an 8-bit core.
// Assumes the core stacks pushed bytes, returns vector bytes one cycle after a
// fetch strobe, and holds instruction execution while core_halt or a sequence runs.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
module vectored_interrupt_unit
  import vectored_interrupt_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        reset_pin,
  input  wire logic        external_edge_input,
  input  wire logic [7:0]  port_a_in,
  input  wire logic        port_a_read,
  input  wire logic        dac_reload,
  input  wire logic        timer_zero_overflow,
  input  wire logic        timer_one_overflow,
  input  wire logic        base_timer_overflow,
  input  wire logic        break_req,
  input  wire logic        mask_flag,
  input  wire logic [15:0] core_pc,
  input  wire logic [7:0]  core_status,
  output logic             stack_push,
  output logic      [7:0]  stack_data,
  output logic             vec_rd,
  output logic      [15:0] vec_addr,
  input  wire logic [7:0]  vec_data,
  output logic             pc_load,
  output logic      [15:0] pc_value,
  output logic             set_mask,
  output logic             clear_decimal,
  output logic             core_halt,
  output logic             irq
);

  // ****************************************************************
  // Pin filtering
  // ****************************************************************
  logic [9:0] pins_stable;
  pin_filter #(
    .WIDTH       (10),
    .RESET_VALUE (10'h000)
  ) u_pin_filter (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .pin_in  ({port_a_in, external_edge_input, reset_pin}),
    .stable  (pins_stable)
  );

  wire       reset_level = pins_stable[0];
  wire       ext_level   = pins_stable[1];
  wire [7:0] port_level  = pins_stable[9:2];

  // ****************************************************************
  // State
  // ****************************************************************
  seq_state_e                    state;
  seq_state_e                    next_state;
  logic [SOURCE_COUNT-1:0]       interrupt_request_flags;
  logic [SOURCE_COUNT-1:0]       interrupt_enable_mask;
  logic                          edge_polarity_select;
  logic [EVENT_COUNT-1:0]        event_status;
  logic [EVENT_COUNT-1:0]        event_mask;
  logic                          ext_level_prev;
  logic [7:0]                    port_latched;
  logic                          break_pending;
  logic                          entry_is_break;
  logic [1:0]                    low_count;
  logic [2:0]                    init_count;
  logic [15:0]                   vec_base;
  logic [15:0]                   saved_pc;
  logic [7:0]                    saved_status;
  logic [15:0]                   next_vec_base;
  logic [15:0]                   next_pc_value;
  logic                          next_entry_is_break;
  logic                          next_stack_push;
  logic [7:0]                    next_stack_data;
  logic                          next_vec_rd;
  logic [15:0]                   next_vec_addr;
  logic                          next_pc_load;
  logic                          next_set_mask;
  logic                          next_clear_decimal;
  logic [SOURCE_COUNT-1:0]       service_clear;
  logic                          hw_taken;
  logic                          break_taken;
  logic                          reset_done;
  logic                          hi_due;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire write_request = reg_wr && (reg_addr == REQUEST_FLAGS_OFFSET);
  wire write_enable  = reg_wr && (reg_addr == ENABLE_MASK_OFFSET);
  wire write_edge    = reg_wr && (reg_addr == EDGE_CONTROL_OFFSET);
  wire write_emask   = reg_wr && (reg_addr == EVENT_MASK_OFFSET);
  wire read_estatus  = reg_rd && (reg_addr == EVENT_STATUS_OFFSET);

  logic [7:0] read_value;
  always_comb begin
    if (reg_addr == REQUEST_FLAGS_OFFSET) begin
      read_value = {2'b00, interrupt_request_flags};
    end else if (reg_addr == ENABLE_MASK_OFFSET) begin
      read_value = {2'b00, interrupt_enable_mask};
    end else if (reg_addr == EDGE_CONTROL_OFFSET) begin
      read_value = 8'h00;
      read_value[EDGE_POLARITY_BIT] = edge_polarity_select;
    end else if (reg_addr == EVENT_STATUS_OFFSET) begin
      read_value = {5'b00000, event_status};
    end else if (reg_addr == EVENT_MASK_OFFSET) begin
      read_value = {5'b00000, event_mask};
    end else begin
      read_value = 8'h00;
    end
  end

  // ****************************************************************
  // Event detection
  // ****************************************************************
  // edge polarity choice
  wire ext_edge = edge_polarity_select ? (ext_level && !ext_level_prev)
                                       : (!ext_level && ext_level_prev);
  wire port_change = (port_level != port_latched);

  logic [SOURCE_COUNT-1:0] source_set;
  always_comb begin
    source_set = '0;
    source_set[EXT_EDGE_BIT]    = ext_edge;
    source_set[DAC_RELOAD_BIT]  = dac_reload;
    source_set[TIMER_ZERO_BIT]  = timer_zero_overflow;
    source_set[TIMER_ONE_BIT]   = timer_one_overflow;
    source_set[PORT_CHANGE_BIT] = port_change;
    source_set[BASE_TIMER_BIT]  = base_timer_overflow;
  end

  // ****************************************************************
  // Priority selection
  // ****************************************************************
  wire [SOURCE_COUNT-1:0] eligible = interrupt_request_flags & interrupt_enable_mask;
  logic [SOURCE_COUNT-1:0] winner;
  logic [15:0]             winner_vector;
  always_comb begin
    winner        = '0;
    winner_vector = RESERVED_VECTOR;
    for (int i = SOURCE_COUNT - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        winner        = '0;
        winner[i]     = 1'b1;
        winner_vector = SOURCE_VECTOR[i];
      end
    end
  end
  wire any_eligible = |eligible;

  // ****************************************************************
  // Reset pin supervision
  // ****************************************************************
  // two low cycles halt
  wire halt_now = !reset_level && (low_count == LOW_HOLD_CYCLES - 2'd1);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    next_state          = state;
    next_vec_base       = vec_base;
    next_pc_value       = pc_value;
    next_entry_is_break = entry_is_break;
    next_stack_push     = 1'b0;
    next_stack_data     = stack_data;
    next_vec_rd         = 1'b0;
    next_vec_addr       = vec_addr;
    next_pc_load        = 1'b0;
    next_set_mask       = 1'b0;
    next_clear_decimal  = 1'b0;
    service_clear       = '0;
    hw_taken            = 1'b0;
    break_taken         = 1'b0;
    reset_done          = 1'b0;
    case (state)
      ST_HALT: begin
        if (reset_level) begin
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        if (init_count == INIT_CYCLES - 3'd1) begin
          next_set_mask      = 1'b1;
          next_clear_decimal = 1'b1;
          next_vec_base      = RESET_VECTOR;
          reset_done         = 1'b1;
          next_state         = ST_FETCH_LO;
        end
      end
      ST_IDLE: begin
        if (!mask_flag && any_eligible) begin
          service_clear       = winner;
          hw_taken            = 1'b1;
          next_vec_base       = winner_vector;
          next_entry_is_break = 1'b0;
          next_state          = ST_PUSH_HI;
        end else if (!mask_flag && break_pending) begin
          break_taken         = 1'b1;
          next_vec_base       = BREAK_VECTOR;
          next_entry_is_break = 1'b1;
          next_state          = ST_PUSH_HI;
        end
      end
      ST_PUSH_HI: begin
        next_stack_push = 1'b1;
        next_stack_data = saved_pc[15:8];
        next_state      = ST_PUSH_LO;
      end
      ST_PUSH_LO: begin
        next_stack_push = 1'b1;
        next_stack_data = saved_pc[7:0];
        next_state      = ST_PUSH_P;
      end
      ST_PUSH_P: begin
        next_stack_push = 1'b1;
        next_stack_data = saved_status;
        next_stack_data[STATUS_BREAK_BIT] = entry_is_break;
        next_set_mask   = 1'b1;
        next_state      = ST_FETCH_LO;
      end
      ST_FETCH_LO: begin
        next_vec_rd   = 1'b1;
        next_vec_addr = vec_base;
        next_state    = ST_FETCH_HI;
      end
      ST_FETCH_HI: begin
        next_vec_rd   = 1'b1;
        next_vec_addr = vec_base + 16'd1;
        next_state    = ST_LOAD;
      end
      ST_LOAD: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_HALT;
      end
    endcase
    // Vector bytes arrive one cycle after each fetch strobe
    if (vec_rd && (vec_addr != vec_base)) begin
      next_pc_value[7:0] = vec_data;
    end
    if (hi_due) begin
      next_pc_value[15:8] = vec_data;
      next_pc_load        = 1'b1;
    end
    if (halt_now) begin
      next_state      = ST_HALT;
      next_stack_push = 1'b0;
      next_vec_rd     = 1'b0;
      next_pc_load    = 1'b0;
      next_set_mask   = 1'b0;
      service_clear   = '0;
      hw_taken        = 1'b0;
      break_taken     = 1'b0;
      reset_done      = 1'b0;
    end
  end

  // ****************************************************************
  // Request and enable registers
  // ****************************************************************
  // write zero clears, set wins
  wire [SOURCE_COUNT-1:0] sw_clear = write_request ? ~reg_wdata[SOURCE_COUNT-1:0] : '0;
  wire [SOURCE_COUNT-1:0] next_request =
    (interrupt_request_flags & ~sw_clear & ~service_clear) | source_set;

  wire [EVENT_COUNT-1:0] event_set = {hw_taken, break_taken, reset_done};
  wire [EVENT_COUNT-1:0] next_event =
    (read_estatus ? '0 : event_status) | event_set;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      interrupt_request_flags <= REQUEST_RESET;
      interrupt_enable_mask   <= ENABLE_RESET;
      edge_polarity_select    <= 1'b0;
      event_status            <= EVENT_RESET_VALUE;
      event_mask              <= EVENT_RESET_VALUE;
      reg_rdata               <= 8'h00;
      irq                     <= 1'b0;
    end else if (clk_en) begin
      interrupt_request_flags <= next_request;
      if (write_enable) begin
        interrupt_enable_mask <= reg_wdata[SOURCE_COUNT-1:0];
      end
      if (write_edge) begin
        edge_polarity_select <= reg_wdata[EDGE_POLARITY_BIT];
      end
      if (write_emask) begin
        event_mask <= reg_wdata[EVENT_COUNT-1:0];
      end
      event_status <= next_event;
      reg_rdata    <= reg_rd ? read_value : 8'h00;
      irq          <= |(next_event & event_mask);
    end
  end

  // ****************************************************************
  // Input history
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ext_level_prev <= 1'b0;
      port_latched   <= 8'h00;
      break_pending  <= 1'b0;
      low_count      <= 2'd0;
      init_count     <= 3'd0;
      hi_due         <= 1'b0;
    end else if (clk_en) begin
      ext_level_prev <= ext_level;
      if (port_a_read) begin
        port_latched <= port_level;
      end
      // Break waits while hardware sources win; a new break wins over the clear
      break_pending <= break_req || (break_pending && !break_taken && !halt_now);
      low_count     <= reset_level ? 2'd0 :
                       (low_count == LOW_HOLD_CYCLES - 2'd1) ? low_count : low_count + 2'd1;
      init_count    <= (state == ST_INIT) ? init_count + 3'd1 : 3'd0;
      hi_due        <= vec_rd && (vec_addr != vec_base) && !halt_now;
    end
  end

  // ****************************************************************
  // Sequencer and core-facing outputs
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state          <= ST_HALT;
      vec_base       <= RESET_VECTOR;
      entry_is_break <= 1'b0;
      saved_pc       <= 16'h0000;
      saved_status   <= 8'h00;
      stack_push     <= 1'b0;
      stack_data     <= 8'h00;
      vec_rd         <= 1'b0;
      vec_addr       <= 16'h0000;
      pc_load        <= 1'b0;
      pc_value       <= 16'h0000;
      set_mask       <= 1'b0;
      clear_decimal  <= 1'b0;
      core_halt      <= 1'b1;
    end else if (clk_en) begin
      state          <= next_state;
      vec_base       <= next_vec_base;
      entry_is_break <= next_entry_is_break;
      if (state == ST_IDLE) begin
        saved_pc     <= core_pc;
        saved_status <= core_status;
      end
      stack_push     <= next_stack_push;
      stack_data     <= next_stack_data;
      vec_rd         <= next_vec_rd;
      vec_addr       <= next_vec_addr;
      pc_load        <= next_pc_load;
      pc_value       <= next_pc_value;
      set_mask       <= next_set_mask;
      clear_decimal  <= next_clear_decimal;
      // Core runs only in idle; it stalls through entry sequences
      core_halt      <= (next_state != ST_IDLE);
    end
  end

endmodule : vectored_interrupt_unit

// File: bench/core_model.sv
// Core stand-in: holds the mask flag and answers vector byte fetches.
// Assumes the unit's fetch strobe and a bench pulse that clears the mask.
`timescale 1ns/1ns
module core_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        cli,
  input  wire logic        set_mask,
  input  wire logic        vec_rd,
  input  wire logic [15:0] vec_addr,
  output logic             mask_flag = 1'b1,
  output logic      [7:0]  vec_data = 8'h00
);
  // ****************************************************************
  // Mask flag and vector bytes
  // ****************************************************************
  always @(posedge ref_clk) begin
    if (!rst_b || set_mask)
      mask_flag <= 1'b1;
    else if (cli)
      mask_flag <= 1'b0;
    // Idle bus toggles so a late sample never matches by luck
    if (vec_rd)
      vec_data <= vec_addr[7:0] ^ 8'h5a;
    else
      vec_data <= ~vec_data;
  end
endmodule : core_model

// File: bench/vec_unit_asserts.sv
// Port checker for the vectored interrupt unit.
// Assumes a bind onto the unit top; sees its ports only.
`timescale 1ns/1ns
module vec_unit_asserts (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        mask_flag,
  input wire logic        stack_push,
  input wire logic        set_mask,
  input wire logic        clear_decimal,
  input wire logic        vec_rd,
  input wire logic [15:0] vec_addr,
  input wire logic        pc_load,
  input wire logic        core_halt
);
  // ****************************************************************
  // Entry sequence
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_push_run: assert property ($rose(stack_push) |=> stack_push ##1
    (stack_push && set_mask) ##1 !stack_push) else $error("push run wrong");
  a_unmasked_entry: assert property ($rose(stack_push) |-> !$past(mask_flag))
    else $error("entry while masked");
  a_fetch_pair: assert property ($rose(vec_rd) |=> vec_rd &&
    vec_addr == $past(vec_addr) + 16'h1 ##1 !vec_rd) else $error("fetch pair wrong");
  a_mask_first: assert property (set_mask |-> ##[1:3] $rose(vec_rd))
    else $error("no fetch after mask");
  a_load_after: assert property (pc_load |-> $past(vec_rd, 2) && $past(vec_rd, 3))
    else $error("load without fetch");
  a_decimal_mask: assert property (clear_decimal |-> set_mask && !stack_push)
    else $error("decimal clear alone");
  a_no_reserved: assert property (vec_rd |-> vec_addr[15:1] != 15'h3ffd)
    else $error("reserved vector fetched");
  a_vec_window: assert property (vec_rd |-> vec_addr >= 16'h7fee)
    else $error("vector out of table");
  a_halt_busy: assert property ((stack_push || vec_rd) |-> core_halt)
    else $error("sequence without halt");
  cover property ($rose(stack_push));
  cover property (clear_decimal);
  cover property (pc_load && !core_halt);
endmodule : vec_unit_asserts

// File: bench/test_vectored_interrupt_unit.sv
// Self-checking bench for the vectored interrupt unit.
// Assumes the core model partner and the bound port checker.
`timescale 1ns/1ns
module test_vectored_interrupt_unit;
  import vectored_interrupt_pkg::*;
  logic        ref_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cli = 1'b0, rp = 1'b1;
  logic        ext_in = 1'b0, mask_flag, stack_push, vec_rd, pc_load, set_mask, irq;
  logic [6:0]  ev = 7'h00;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, stack_data, vec_data;
  logic [7:0]  pa_in = 8'h00, st_now = 8'h00, pushed[$];
  logic [15:0] pc_now = 16'h0000, vec_addr, pc_value;
  int          fails = 0, comparisons = 0, bits[4] = '{1, 2, 3, 5};
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (stack_push) pushed.push_back(stack_data);
  // Clock enable tied high: the bench has one clock and never stalls it
  vectored_interrupt_unit uut (.ref_clk, .rst_b, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .reset_pin(rp), .external_edge_input(ext_in), .port_a_in(pa_in),
    .port_a_read(ev[4]), .dac_reload(ev[1]), .timer_zero_overflow(ev[2]),
    .timer_one_overflow(ev[3]), .base_timer_overflow(ev[5]), .break_req(ev[6]), .mask_flag,
    .core_pc(pc_now), .core_status(st_now), .stack_push, .stack_data, .vec_rd, .vec_addr,
    .vec_data, .pc_load, .pc_value, .set_mask, .clear_decimal(), .core_halt(), .irq);
  core_model partner (.ref_clk, .rst_b, .cli, .set_mask, .vec_rd, .vec_addr, .mask_flag,
    .vec_data);
  // ****************************************************************
  // Tasks
  // ****************************************************************
  function automatic logic [15:0] vec_word(logic [15:0] v);
    return {(v[7:0] + 8'h01) ^ 8'h5a, v[7:0] ^ 8'h5a};
  endfunction : vec_word
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic fire(logic [6:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 7'h00;
  endtask : fire
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check($sformatf("reg %h", a), reg_rdata, exp);
  endtask : rd
  task automatic irq_is(logic exp);
    repeat (2) @(posedge ref_clk);
    #1 check("irq", irq, exp);
  endtask : irq_is
  // Kind 0 reset entry, 1 hardware, 2 break; unmasks, then waits for the load
  task automatic serve(logic [15:0] vec, int kind);
    @(posedge ref_clk);
    cli <= 1'b1;
    @(posedge ref_clk);
    cli <= 1'b0;
    for (int i = 0; i < 60 && pc_load !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (pc_load !== 1'b1) begin
      fails++;
      print_verdict();
    end
    check("pc", pc_value, vec_word(vec));
    if (kind == 0) begin
      check("pushes", 16'(pushed.size()), 16'h0000);
    end else begin
      check("pch", pushed[0], pc_now[15:8]);
      check("pcl", pushed[1], pc_now[7:0]);
      check("status", pushed[2], {st_now[7:5], kind == 2, st_now[3:0]});
    end
    pushed.delete();
    @(posedge ref_clk);
    pc_now <= 16'($urandom);
    st_now <= 8'($urandom);
  endtask : serve
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(11));
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    serve(RESET_VECTOR, 0);
    rd(REQUEST_FLAGS_OFFSET, 8'h00);
    rd(ENABLE_MASK_OFFSET, 8'h00);
    rd(8'h55, 8'h00);
    wr(ENABLE_MASK_OFFSET, 8'hff);
    rd(ENABLE_MASK_OFFSET, 8'h3f);
    wr(EVENT_MASK_OFFSET, 8'h07);
    foreach (bits[k]) begin
      fire(7'h01 << bits[k]);
      rd(REQUEST_FLAGS_OFFSET, 8'h01 << bits[k]);
      serve(SOURCE_VECTOR[bits[k]], 1);
      rd(REQUEST_FLAGS_OFFSET, 8'h00);
    end
    fire(7'h2c);
    serve(SOURCE_VECTOR[2], 1);
    rd(REQUEST_FLAGS_OFFSET, 8'h28);
    wr(REQUEST_FLAGS_OFFSET, 8'hdf);
    rd(REQUEST_FLAGS_OFFSET, 8'h08);
    wr(ENABLE_MASK_OFFSET, 8'h37);
    fire(7'h00);
    cli <= 1'b1;
    repeat (12) @(posedge ref_clk);
    cli <= 1'b0;
    check("held", 16'(pushed.size()), 16'h0000);
    wr(ENABLE_MASK_OFFSET, 8'h3f);
    serve(SOURCE_VECTOR[3], 1);
    fire(7'h40);
    serve(BREAK_VECTOR, 2);
    wr(EDGE_CONTROL_OFFSET, 8'h20);
    ext_in <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(REQUEST_FLAGS_OFFSET, 8'h01);
    serve(SOURCE_VECTOR[0], 1);
    wr(EDGE_CONTROL_OFFSET, 8'h00);
    ext_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(REQUEST_FLAGS_OFFSET, 8'h01);
    wr(REQUEST_FLAGS_OFFSET, 8'h00);
    pa_in <= 8'($urandom_range(255, 1));
    repeat (6) @(posedge ref_clk);
    rd(REQUEST_FLAGS_OFFSET, 8'h10);
    serve(SOURCE_VECTOR[4], 1);
    fire(7'h10);
    wr(REQUEST_FLAGS_OFFSET, 8'h00);
    rd(REQUEST_FLAGS_OFFSET, 8'h00);
    rp <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rp <= 1'b1;
    serve(RESET_VECTOR, 0);
    wr(EVENT_MASK_OFFSET, 8'h00);
    irq_is(1'b0);
    wr(EVENT_MASK_OFFSET, 8'h02);
    irq_is(1'b1);
    rd(EVENT_STATUS_OFFSET, 8'h07);
    irq_is(1'b0);
    print_verdict();
  end
endmodule : test_vectored_interrupt_unit
bind vectored_interrupt_unit vec_unit_asserts checker_inst (.ref_clk, .rst_b, .mask_flag,
  .stack_push, .set_mask, .clear_decimal, .vec_rd, .vec_addr, .pc_load, .core_halt);
